// ---- rtl/imsf_regs_defs.vh ----
// Constants for the motion status, queue level and identity register slice.
// Assumes an APB slave with one aligned 32-bit word per register index.
`ifndef IMSF_REGS_DEFS_VH
`define IMSF_REGS_DEFS_VH

// Register indices, byte address is four times the index
`define IMSF_IDX_WAKE_STAT    10'h03b
`define IMSF_IDX_GEST_STAT    10'h03c
`define IMSF_IDX_LEVEL_UPPER  10'h03d
`define IMSF_IDX_LEVEL_LOWER  10'h03e
`define IMSF_IDX_READ_PORT    10'h03f
`define IMSF_IDX_IDENTITY     10'h075
`define IMSF_IDX_BANK_SEL     10'h079
`define IMSF_IDX_LEVEL_CFG    10'h080
`define IMSF_IDX_IRQ_STAT     10'h081
`define IMSF_IDX_IRQ_EN       10'h082
`define IMSF_IDX_IRQ_CLR      10'h083

// Wake status field positions
`define IMSF_WAKE_SIG_MOTION  3
`define IMSF_WAKE_X           2
`define IMSF_WAKE_Y           1
`define IMSF_WAKE_Z           0
`define IMSF_WAKE_LSB         0
`define IMSF_WAKE_W           4

// Gesture status field positions
`define IMSF_GEST_STEP        5
`define IMSF_GEST_STEP_OVF    4
`define IMSF_GEST_TILT        3
`define IMSF_GEST_FREEFALL    2
`define IMSF_GEST_LOW_ACCEL   1
`define IMSF_GEST_LSB         1
`define IMSF_GEST_W           5

// Level configuration field positions
`define IMSF_CFG_UNIT_REC     6
`define IMSF_CFG_BIG_ENDIAN   5
`define IMSF_CFG_SMALL_REC    0
`define IMSF_CFG_MASK         8'h61

// Interrupt status layout: gesture events above wake events
`define IMSF_IRQ_W            9

// Record sizes as shift amounts (16 bytes, 8 bytes)
`define IMSF_REC_FULL_SHIFT   4
`define IMSF_REC_SMALL_SHIFT  3

// Reset values
`define IMSF_RST_STAT         8'h00
`define IMSF_RST_LEVEL        8'h00
`define IMSF_RST_PORT_EMPTY   8'hff
`define IMSF_RST_BANK_SEL     8'h00
`define IMSF_RST_LEVEL_CFG    8'h00
`define IMSF_RST_IRQ_EN       9'h000

`endif

// ---- rtl/imsf_flag_bank.v ----
// Sticky event flags, one flip-flop per bit, set wins over clear.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module imsf_flag_bank #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [W-1:0] set_vec,
    input  wire [W-1:0] clr_vec,
    output wire [W-1:0] flags
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_flag
            reg flag_r;
            always @(posedge clk) begin
                if (!rstn) begin
                    flag_r <= 1'b0;
                end else if (set_vec[i]) begin
                    flag_r <= 1'b1;
                end else if (clr_vec[i]) begin
                    flag_r <= 1'b0;
                end
            end
            assign flags[i] = flag_r;
        end
    endgenerate

endmodule // imsf_flag_bank

`default_nettype wire

// ---- rtl/imsf_level_view.v ----
// Queue fill level formatting and two-byte snapshot.
// Assumes the level input is a byte count from the queue on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "imsf_regs_defs.vh"

module imsf_level_view (
    input  wire        clk,
    input  wire        rstn,
    input  wire [15:0] level_bytes,
    input  wire        unit_rec,
    input  wire        small_rec,
    input  wire        big_endian,
    input  wire        snap,
    output wire [7:0]  fresh_lower,
    output wire [7:0]  snap_upper,
    output wire [7:0]  snap_lower
);

    reg  [7:0]  upper_r;
    reg  [7:0]  lower_r;
    wire [15:0] level_units;
    wire [7:0]  view_upper;
    wire [7:0]  view_lower;

    // Bytes or records
    assign level_units = !unit_rec  ? level_bytes :
                         small_rec  ? (level_bytes >> `IMSF_REC_SMALL_SHIFT) :
                                      (level_bytes >> `IMSF_REC_FULL_SHIFT);

    // Byte order of the pair
    assign view_upper = big_endian ? level_units[7:0]  : level_units[15:8];
    assign view_lower = big_endian ? level_units[15:8] : level_units[7:0];

    assign fresh_lower = view_lower;

    // Both bytes refresh together
    always @(posedge clk) begin
        if (!rstn) begin
            upper_r <= `IMSF_RST_LEVEL;
            lower_r <= `IMSF_RST_LEVEL;
        end else if (snap) begin
            upper_r <= view_upper;
            lower_r <= view_lower;
        end
    end

    assign snap_upper = upper_r;
    assign snap_lower = lower_r;

endmodule // imsf_level_view

`default_nettype wire

// ---- rtl/imsf_status_regs.v ----
// APB register slice: motion status, queue level and read port, identity,
// extended bank select, level configuration and interrupt registers.
// Assumes motion events and queue signals come from logic on clk.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "imsf_regs_defs.vh"

module imsf_status_regs #(
    parameter [7:0] IDENTITY_VALUE = 8'h5a // Arbitrary value
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        evt_sig_motion,
    input  wire        evt_wake_x,
    input  wire        evt_wake_y,
    input  wire        evt_wake_z,
    input  wire        evt_step,
    input  wire        evt_step_ovf,
    input  wire        evt_tilt,
    input  wire        evt_freefall,
    input  wire        evt_low_accel,
    input  wire [15:0] queue_level_bytes,
    input  wire [7:0]  queue_head_data,
    output wire        queue_pop,
    output wire [7:0]  ext_bank_sel,
    output wire        irq
);

    // Bus phases
    wire        setup_ph;
    wire        access_ph;
    wire        acc_rd;
    wire        acc_wr;
    wire [9:0]  idx;
    wire        addr_ok;
    wire        lane0;
    wire        lane1;

    // Register hits
    wire        hit_wake;
    wire        hit_gest;
    wire        hit_lower;
    wire        hit_port;
    wire        hit_bank;
    wire        hit_cfg;
    wire        hit_ien;
    wire        hit_iclr;

    // Access phase strobes
    wire        rd_wake;
    wire        rd_gest;
    wire        rd_port;
    wire        wr_bank;
    wire        wr_cfg;
    wire        wr_ien;
    wire        wr_iclr;

    // Read capture
    reg  [31:0] prdata_r;
    reg  [31:0] prdata_nxt;
    reg         slverr_r;
    reg         slverr_nxt;

    // Software state
    reg  [7:0]  bank_sel_r;
    reg  [7:0]  level_cfg_r;
    reg  [8:0]  irq_en_r;
    reg  [7:0]  bank_sel_nxt;
    reg  [7:0]  level_cfg_nxt;
    reg  [8:0]  irq_en_nxt;
    reg         irq_r;

    // Event vectors
    wire [3:0]  wake_set;
    wire [4:0]  gest_set;
    wire [3:0]  wake_clr;
    wire [4:0]  gest_clr;
    wire [3:0]  wake_flags;
    wire [4:0]  gest_flags;
    wire [8:0]  irq_set;
    wire [8:0]  irq_clr;
    wire [8:0]  irq_flags;
    wire [8:0]  irq_lane_mask;

    // Status bytes
    wire [7:0]  wake_byte;
    wire [7:0]  gest_byte;

    // Level view
    wire        snap_level;
    wire [7:0]  fresh_lower;
    wire [7:0]  snap_upper;
    wire [7:0]  snap_lower;
    wire        queue_empty;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign acc_rd    = access_ph & ~pwrite;
    assign acc_wr    = access_ph & pwrite;
    assign idx       = paddr[11:2];
    assign addr_ok   = (paddr[1:0] == 2'b00);
    assign lane0     = pstrb[0];
    assign lane1     = pstrb[1];

    // Register decode, aligned word addresses only
    assign hit_wake  = addr_ok && (idx == `IMSF_IDX_WAKE_STAT);
    assign hit_gest  = addr_ok && (idx == `IMSF_IDX_GEST_STAT);
    assign hit_lower = addr_ok && (idx == `IMSF_IDX_LEVEL_LOWER);
    assign hit_port  = addr_ok && (idx == `IMSF_IDX_READ_PORT);
    assign hit_bank  = addr_ok && (idx == `IMSF_IDX_BANK_SEL);
    assign hit_cfg   = addr_ok && (idx == `IMSF_IDX_LEVEL_CFG);
    assign hit_ien   = addr_ok && (idx == `IMSF_IDX_IRQ_EN);
    assign hit_iclr  = addr_ok && (idx == `IMSF_IDX_IRQ_CLR);

    // Side effects in the access phase, except the level snapshot taken in the setup phase
    assign rd_wake   = acc_rd & hit_wake;
    assign rd_gest   = acc_rd & hit_gest;
    assign rd_port   = acc_rd & hit_port;
    assign wr_bank   = acc_wr & hit_bank;
    assign wr_cfg    = acc_wr & hit_cfg;
    assign wr_ien    = acc_wr & hit_ien;
    assign wr_iclr   = acc_wr & hit_iclr;

    // Slave always answers in the access phase
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = slverr_r;

    // Motion events into status positions
    assign wake_set[`IMSF_WAKE_SIG_MOTION] = evt_sig_motion;
    assign wake_set[`IMSF_WAKE_X]          = evt_wake_x;
    assign wake_set[`IMSF_WAKE_Y]          = evt_wake_y;
    assign wake_set[`IMSF_WAKE_Z]          = evt_wake_z;

    assign gest_set[`IMSF_GEST_STEP - `IMSF_GEST_LSB]      = evt_step;
    assign gest_set[`IMSF_GEST_STEP_OVF - `IMSF_GEST_LSB]  = evt_step_ovf;
    assign gest_set[`IMSF_GEST_TILT - `IMSF_GEST_LSB]      = evt_tilt;
    assign gest_set[`IMSF_GEST_FREEFALL - `IMSF_GEST_LSB]  = evt_freefall;
    assign gest_set[`IMSF_GEST_LOW_ACCEL - `IMSF_GEST_LSB] = evt_low_accel;

    // Status bytes, reserved positions fixed at zero
    assign wake_byte[`IMSF_WAKE_LSB +: `IMSF_WAKE_W]      = wake_flags;
    assign wake_byte[7:`IMSF_WAKE_W]                      = 4'h0;
    assign gest_byte[`IMSF_GEST_LSB +: `IMSF_GEST_W]      = gest_flags;
    assign gest_byte[7:(`IMSF_GEST_LSB + `IMSF_GEST_W)]   = 2'b00;
    assign gest_byte[0]                                   = 1'b0;

    // Clear only the bits that were returned to the host
    assign wake_clr = rd_wake ? prdata_r[`IMSF_WAKE_LSB +: `IMSF_WAKE_W] : 4'h0;
    assign gest_clr = rd_gest ? prdata_r[`IMSF_GEST_LSB +: `IMSF_GEST_W] : 5'h00;

    imsf_flag_bank #(
        .W (`IMSF_WAKE_W)
    ) u_wake_flags (
        .clk     (clk),
        .rstn    (rstn),
        .set_vec (wake_set),
        .clr_vec (wake_clr),
        .flags   (wake_flags)
    );

    imsf_flag_bank #(
        .W (`IMSF_GEST_W)
    ) u_gest_flags (
        .clk     (clk),
        .rstn    (rstn),
        .set_vec (gest_set),
        .clr_vec (gest_clr),
        .flags   (gest_flags)
    );

    // Interrupt status, write one to clear, set wins
    assign irq_set       = {gest_set, wake_set};
    assign irq_lane_mask = {lane1, {8{lane0}}};
    assign irq_clr       = wr_iclr ? (pwdata[8:0] & irq_lane_mask) : 9'h000;

    imsf_flag_bank #(
        .W (`IMSF_IRQ_W)
    ) u_irq_flags (
        .clk     (clk),
        .rstn    (rstn),
        .set_vec (irq_set),
        .clr_vec (irq_clr),
        .flags   (irq_flags)
    );

    // Interrupt line from a flip-flop
    always @(posedge clk) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_flags & irq_en_r);
        end
    end

    assign irq = irq_r;

    // Snapshot taken as the lower byte is read
    assign snap_level = setup_ph && !pwrite && hit_lower;

    imsf_level_view u_level (
        .clk         (clk),
        .rstn        (rstn),
        .level_bytes (queue_level_bytes),
        .unit_rec    (level_cfg_r[`IMSF_CFG_UNIT_REC]),
        .small_rec   (level_cfg_r[`IMSF_CFG_SMALL_REC]),
        .big_endian  (level_cfg_r[`IMSF_CFG_BIG_ENDIAN]),
        .snap        (snap_level),
        .fresh_lower (fresh_lower),
        .snap_upper  (snap_upper),
        .snap_lower  (snap_lower)
    );

    assign queue_empty = (queue_level_bytes == 16'h0000);

    // Pop the head byte when a port read completes
    assign queue_pop = rd_port && !queue_empty;

    // Read data and error decode in the setup phase
    always @* begin
        prdata_nxt = 32'h0000_0000;
        slverr_nxt = 1'b0;
        if (!addr_ok) begin
            slverr_nxt = 1'b1;
        end else begin
            case (idx)
                `IMSF_IDX_WAKE_STAT: begin
                    prdata_nxt[7:0] = wake_byte;
                    slverr_nxt      = pwrite;
                end
                `IMSF_IDX_GEST_STAT: begin
                    prdata_nxt[7:0] = gest_byte;
                    slverr_nxt      = pwrite;
                end
                `IMSF_IDX_LEVEL_UPPER: begin
                    prdata_nxt[7:0] = snap_upper;
                    slverr_nxt      = pwrite;
                end
                `IMSF_IDX_LEVEL_LOWER: begin
                    prdata_nxt[7:0] = fresh_lower;
                    slverr_nxt      = pwrite;
                end
                `IMSF_IDX_READ_PORT: begin
                    prdata_nxt[7:0] = queue_empty ? `IMSF_RST_PORT_EMPTY :
                                                    queue_head_data;
                    slverr_nxt      = pwrite;
                end
                `IMSF_IDX_IDENTITY: begin
                    prdata_nxt[7:0] = IDENTITY_VALUE;
                    slverr_nxt      = pwrite;
                end
                `IMSF_IDX_BANK_SEL: begin
                    prdata_nxt[7:0] = bank_sel_r;
                end
                `IMSF_IDX_LEVEL_CFG: begin
                    prdata_nxt[7:0] = level_cfg_r;
                end
                `IMSF_IDX_IRQ_STAT: begin
                    prdata_nxt[8:0] = irq_flags;
                    slverr_nxt      = pwrite;
                end
                `IMSF_IDX_IRQ_EN: begin
                    prdata_nxt[8:0] = irq_en_r;
                end
                `IMSF_IDX_IRQ_CLR: begin
                    slverr_nxt = ~pwrite;
                end
                default: begin
                    slverr_nxt = 1'b1;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= pwrite ? 32'h0000_0000 : prdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

    // Writable register next values, lane 0 carries the low byte, lane 1 interrupt enable bit 8
    always @* begin
        bank_sel_nxt  = bank_sel_r;
        level_cfg_nxt = level_cfg_r;
        irq_en_nxt    = irq_en_r;
        if (wr_bank && lane0) begin
            bank_sel_nxt = pwdata[7:0];
        end
        if (wr_cfg && lane0) begin
            level_cfg_nxt = pwdata[7:0] & `IMSF_CFG_MASK;
        end
        if (wr_ien && lane0) begin
            irq_en_nxt[7:0] = pwdata[7:0];
        end
        if (wr_ien && lane1) begin
            irq_en_nxt[8] = pwdata[8];
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            bank_sel_r  <= `IMSF_RST_BANK_SEL;
            level_cfg_r <= `IMSF_RST_LEVEL_CFG;
            irq_en_r    <= `IMSF_RST_IRQ_EN;
        end else begin
            bank_sel_r  <= bank_sel_nxt;
            level_cfg_r <= level_cfg_nxt;
            irq_en_r    <= irq_en_nxt;
        end
    end

    assign ext_bank_sel = bank_sel_r;

endmodule // imsf_status_regs

`default_nettype wire

// ---- testbench/imsf_queue_model.sv ----
// Byte queue on the far side of the read port.
// Assumes pushes come from the bench and pops from the register slice.
`timescale 1ns/1ps
`default_nettype none
module imsf_queue_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        push_en,
    input  wire logic [7:0]  push_data,
    input  wire logic        queue_pop,
    output var  logic [15:0] queue_level_bytes,
    output var  logic [7:0]  queue_head_data
);
    logic [7:0] q[$];
    logic [7:0] gone = 8'h00;
    initial begin
        queue_level_bytes = 16'h0000;
        queue_head_data = 8'h00;
    end
    always @(posedge clk) begin
        if (!rstn) begin
            q.delete();
        end else begin
            if (queue_pop && q.size() > 0) begin
                gone = q.pop_front();
            end
            if (push_en) begin
                q.push_back(push_data);
            end
        end
        queue_level_bytes <= 16'(q.size());
        // Empty queue shows no stale byte
        queue_head_data <= (q.size() > 0) ? q[0] : ~gone;
    end
endmodule // imsf_queue_model
`default_nettype wire

// ---- testbench/imsf_status_regs_asserts.sv ----
// Port checks for the status register slice.
// Assumes it is bound into imsf_status_regs.
`timescale 1ns/1ps
`default_nettype none
module imsf_status_regs_asserts #(
    parameter [7:0] IDENTITY_VALUE = 8'h5a
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        evt_sig_motion,
    input wire logic [15:0] queue_level_bytes,
    input wire logic        queue_pop,
    input wire logic [7:0]  ext_bank_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire        rd_acc = psel && penable && !pwrite;
    wire        wr_acc = psel && penable && pwrite;
    logic [7:0] wd_r;
    always @(posedge clk) begin
        wd_r <= pwdata[7:0];
    end
    chk_motion_flag: assert property (
        rd_acc && paddr == 12'h0ec && $past(rstn, 2) && $past(evt_sig_motion, 2) |-> prdata[3])
        else $error("motion flag lost");
    chk_wake_resv: assert property (
        rd_acc && paddr == 12'h0ec |-> prdata[31:4] == 28'h000_0000)
        else $error("wake reserved bits set");
    chk_gest_resv: assert property (
        rd_acc && paddr == 12'h0f0 |-> prdata[31:6] == 26'h0 && !prdata[0])
        else $error("gesture reserved bits set");
    chk_bank_write: assert property (
        wr_acc && paddr == 12'h1e4 && pstrb[0] |=> ext_bank_sel == wd_r)
        else $error("bank select not written");
    chk_bank_hold: assert property (
        !(wr_acc && paddr == 12'h1e4) |=> $stable(ext_bank_sel))
        else $error("bank select changed");
    chk_pop_cause: assert property (
        queue_pop == (rd_acc && paddr == 12'h0fc && queue_level_bytes != 16'h0000))
        else $error("pop mismatch");
    chk_id_value: assert property (
        rd_acc && paddr == 12'h1d4 |-> prdata == {24'h00_0000, IDENTITY_VALUE} && !pslverr)
        else $error("identity wrong");
    chk_id_write: assert property (
        wr_acc && paddr == 12'h1d4 |-> pslverr)
        else $error("identity write accepted");
    chk_empty_port: assert property (
        rd_acc && paddr == 12'h0fc && $past(queue_level_bytes) == 16'h0000 |-> prdata == 32'h0000_00ff)
        else $error("empty port value wrong");
endmodule // imsf_status_regs_asserts
bind imsf_status_regs imsf_status_regs_asserts #(.IDENTITY_VALUE(IDENTITY_VALUE)) u_chk (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .evt_sig_motion(evt_sig_motion), .queue_level_bytes(queue_level_bytes),
    .queue_pop(queue_pop), .ext_bank_sel(ext_bank_sel));
`default_nettype wire

// ---- testbench/imsf_status_regs_tb_top.sv ----
// Self-checking bench for the status register slice.
// Assumes the queue model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module imsf_status_regs_tb_top;
    localparam logic [7:0] IDV = 8'h3c; // Arbitrary value
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [8:0]  ev;
    logic        push_en;
    logic [7:0]  push_data;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [15:0] qlvl;
    wire  [7:0]  qhead;
    wire         qpop;
    wire  [7:0]  bank;
    wire         irq;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;
    imsf_status_regs #(.IDENTITY_VALUE(IDV)) imsf_status_regs_i (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_sig_motion(ev[3]), .evt_wake_x(ev[2]), .evt_wake_y(ev[1]),
        .evt_wake_z(ev[0]), .evt_step(ev[8]), .evt_step_ovf(ev[7]), .evt_tilt(ev[6]),
        .evt_freefall(ev[5]), .evt_low_accel(ev[4]), .queue_level_bytes(qlvl),
        .queue_head_data(qhead), .queue_pop(qpop), .ext_bank_sel(bank), .irq(irq));
    imsf_queue_model imsf_queue_model_i (
        .clk(clk), .rstn(rstn), .push_en(push_en), .push_data(push_data),
        .queue_pop(qpop), .queue_level_bytes(qlvl), .queue_head_data(qhead));
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic experr);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        if (!w) cmp(prdata, exp);
        cmp({31'h0, pslverr}, {31'h0, experr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic push_n(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            push_en <= 1'b1;
            push_data <= b + i[7:0];
            @(posedge clk);
        end
        push_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset;
        logic [11:0] a[7] = '{12'h0ec, 12'h0f0, 12'h0f4, 12'h0f8, 12'h0fc, 12'h1d4, 12'h1e4};
        logic [7:0]  x[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, IDV, 8'h00};
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, a[i], 32'h0, {24'h0, x[i]}, 1'b0);
        end
    endtask
    task automatic t_port;
        push_n(3, 8'ha1);
        xfer(1'b0, 12'h0fc, 32'h0, 32'h0000_00a1, 1'b0);
        xfer(1'b0, 12'h0f8, 32'h0, 32'h0000_0002, 1'b0);
        xfer(1'b0, 12'h0fc, 32'h0, 32'h0000_00a2, 1'b0);
        xfer(1'b0, 12'h0fc, 32'h0, 32'h0000_00a3, 1'b0);
        xfer(1'b0, 12'h0fc, 32'h0, 32'h0000_00ff, 1'b0);
    endtask
    task automatic t_status;
        logic [8:0] m;
        for (int i = 0; i < 10; i++) begin
            m = (i == 9) ? 9'h1ff : 9'h001 << i;
            ev <= m;
            @(posedge clk);
            ev <= 9'h000;
            xfer(1'b0, 12'h0ec, 32'h0, {28'h0, m[3:0]}, 1'b0);
            xfer(1'b0, 12'h0ec, 32'h0, 32'h0, 1'b0);
            xfer(1'b0, 12'h0f0, 32'h0, {26'h0, m[8:4], 1'b0}, 1'b0);
            xfer(1'b0, 12'h0f0, 32'h0, 32'h0, 1'b0);
        end
    endtask
    task automatic t_irq(input logic en, input logic [8:0] m);
        xfer(1'b1, 12'h20c, 32'h0000_01ff, 32'h0, 1'b0);
        xfer(1'b1, 12'h208, {31'h0, en} * 32'h0000_01ff, 32'h0, 1'b0);
        ev <= m;
        @(posedge clk);
        ev <= 9'h000;
        repeat (3) @(posedge clk);
        cmp({31'h0, irq}, {31'h0, en});
        xfer(1'b0, 12'h204, 32'h0, {23'h0, m}, 1'b0);
        xfer(1'b1, 12'h20c, {23'h0, m}, 32'h0, 1'b0);
        repeat (2) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        xfer(1'b0, 12'h20c, 32'h0, 32'h0, 1'b1);
    endtask
    task automatic t_level;
        logic [7:0] c[4] = '{8'h00, 8'h20, 8'h40, 8'h41};
        logic [7:0] lo[4] = '{8'h23, 8'h01, 8'h12, 8'h24};
        logic [7:0] hi[4] = '{8'h01, 8'h23, 8'h00, 8'h00};
        push_n(291, 8'h00);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 12'h200, {24'h0, c[i]}, 32'h0, 1'b0);
            xfer(1'b0, 12'h0f8, 32'h0, {24'h0, lo[i]}, 1'b0);
            xfer(1'b0, 12'h0f4, 32'h0, {24'h0, hi[i]}, 1'b0);
        end
        xfer(1'b1, 12'h200, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 12'h0f8, 32'h0, 32'h0000_0023, 1'b0);
        push_n(256, 8'h00);
        xfer(1'b0, 12'h0f4, 32'h0, 32'h0000_0001, 1'b0);
        xfer(1'b0, 12'h0f8, 32'h0, 32'h0000_0023, 1'b0);
        xfer(1'b0, 12'h0f4, 32'h0, 32'h0000_0002, 1'b0);
    endtask
    task automatic t_bank;
        xfer(1'b1, 12'h1e4, 32'hffff_ff5a, 32'h0, 1'b0);
        xfer(1'b0, 12'h1e4, 32'h0, 32'h0000_005a, 1'b0);
        cmp({24'h0, bank}, 32'h0000_005a);
        xfer(1'b1, 12'h1d4, 32'h0, 32'h0, 1'b1);
        xfer(1'b0, 12'h1d4, 32'h0, {24'h0, IDV}, 1'b0);
        xfer(1'b0, 12'h300, 32'h0, 32'h0, 1'b1);
        xfer(1'b0, 12'h1e5, 32'h0, 32'h0, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ev = 9'h000;
        push_en = 1'b0;
        push_data = 8'h00;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_port;
        t_status;
        t_irq(1'b1, 9'h020);
        t_irq(1'b0, 9'h001);
        t_level;
        t_bank;
        end_sim;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            end_sim;
        end
    end
endmodule // imsf_status_regs_tb_top
`default_nettype wire
